/* bench/icp_control_port_bench.sv */
/* Bench of the control port: strap addressing, register traffic,
   back-channel access and proxy master arbitration.
   Assumes the host model and a 200 MHz core clock. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    errors++; $display("ERROR %s exp %h seen %h", nm, e, g); end end
module icp_control_port_bench;
    import icp_pkg::*;
    logic         core_clk, rstn, h_scl_low, h_sda_low, comp_sda_low;
    logic         sda_oe, sda_out, m_scl_oe, m_scl_out, m_sda_oe, m_sda_out;
    logic         rem_req_valid, rem_req_ready, rem_rd_valid, ok, held;
    logic         pm_cmd_valid, pm_cmd_ready, pm_done, pm_ack_ok;
    logic         n0, n1, n2, n3, comp_scl_low;
    logic [2:0]   strap;
    logic [7:0]   rem_rd_data, pm_rd_data, rx;
    logic [15:0]  rd2;
    icp_reg_req_t rem_req;
    icp_pm_cmd_t  pm_cmd;
    int           errors, n_compared;
    wire          scl   = ~h_scl_low;
    wire          sda   = ~(h_sda_low | sda_oe);
    wire          m_scl = ~(m_scl_oe | comp_scl_low);
    wire          m_sda = ~(m_sda_oe | comp_sda_low);
    localparam logic [6:0] EXP_ADDR [8] = '{7'h2C, 7'h2E, 7'h30, 7'h32,
                                          7'h34, 7'h36, 7'h38, 7'h3C};

    icp_host_model i_host (.core_clk(core_clk), .sda(sda),
                           .scl_low(h_scl_low), .sda_low(h_sda_low));
    icp_control_port i_dut (.core_clk(core_clk), .rstn(rstn),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .address_select_strap(strap), .rem_req_valid(rem_req_valid),
        .rem_req(rem_req), .rem_req_ready(rem_req_ready),
        .rem_rd_valid(rem_rd_valid), .rem_rd_data(rem_rd_data),
        .pm_cmd_valid(pm_cmd_valid), .pm_cmd(pm_cmd),
        .pm_cmd_ready(pm_cmd_ready), .pm_done(pm_done),
        .pm_ack_ok(pm_ack_ok), .pm_rd_data(pm_rd_data),
        .m_scl_in(m_scl), .m_sda_in(m_sda), .m_scl_out(m_scl_out),
        .m_scl_oe(m_scl_oe), .m_sda_out(m_sda_out), .m_sda_oe(m_sda_oe));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ********************************************
    // Transfers
    // ********************************************
    task automatic wr_txn(input logic [6:0] a, input logic [7:0] off, d);
        i_host.start();
        i_host.xfer({a, 1'b0}, 1'b1, rx, n0);
        i_host.xfer(off, 1'b1, rx, n1);
        i_host.xfer(d, 1'b1, rx, n2);
        i_host.stop();
        ok = ~(n0 | n1 | n2);
    endtask

    task automatic rd_txn(input logic [6:0] a, input logic [7:0] off);
        i_host.start();
        i_host.xfer({a, 1'b0}, 1'b1, rx, n0);
        i_host.xfer(off, 1'b1, rx, n1);
        i_host.start();
        i_host.xfer({a, 1'b1}, 1'b1, rx, n2);
        i_host.xfer(8'hFF, 1'b0, rd2[15:8], n3);
        i_host.xfer(8'hFF, 1'b1, rd2[7:0], n3);
        i_host.stop();
    endtask

    // Remote register requests, one request per call
    task automatic rem(input logic wr, input logic [7:0] off, d);
        @(negedge core_clk);
        rem_req_valid = 1'b1;
        rem_req = {wr, off, d};
        do @(posedge core_clk); while (rem_req_ready !== 1'b1);
        @(negedge core_clk);
        rem_req_valid = 1'b0;
        if (!wr) `CHK("remote valid", 1'b1, rem_rd_valid)
    endtask

    // ********************************************
    // Scenarios
    // ********************************************
    task automatic t_strap();
        for (int s = 0; s < 8; s++) begin
            strap = 3'(s);
            i_host.start();
            i_host.xfer({EXP_ADDR[s], 1'b0}, 1'b1, rx, n0);
            i_host.stop();
            `CHK("own address ack", 1'b0, n0)
            i_host.start();
            i_host.xfer({EXP_ADDR[s] + 7'h01, 1'b0}, 1'b1, rx, n0);
            i_host.stop();
            `CHK("other address nack", 1'b1, n0)
        end
    endtask

    task automatic t_regs();
        strap = 3'd3;
        wr_txn(7'h32, 8'h05, 8'hA5);
        `CHK("write ack", 1'b1, ok)
        wr_txn(7'h32, 8'h06, 8'h3C);
        rd_txn(7'h32, 8'h05);
        `CHK("read pair", 16'hA53C, rd2)
    endtask

    task automatic t_remote();
        rem(1'b0, 8'h05, 8'h00);
        `CHK("remote read", 8'hA5, rem_rd_data)
        rem(1'b1, 8'h07, 8'h5A);
        rd_txn(7'h32, 8'h07);
        `CHK("remote write seen", 16'h5A00, rd2)
        @(negedge core_clk);
        rem_req = {1'b1, 8'h18, 8'hC3};
        rem_req_valid = 1'b1;
        wr_txn(7'h32, 8'h19, 8'h77);
        rem_req_valid = 1'b0;
        `CHK("local write beside remote", 1'b1, ok)
        rd_txn(7'h32, 8'h18);
        `CHK("mailbox pair", 16'hC377, rd2)
    endtask

    task automatic t_override();
        wr_txn(7'h32, 8'h00, {7'h41, 1'b1});
        wr_txn(7'h32, 8'h10, 8'h11);
        `CHK("strap address off", 1'b0, ok)
        wr_txn(7'h41, 8'h00, 8'h64);
        `CHK("override address", 1'b1, ok)
        rem(1'b0, 8'h00, 8'h00);
        `CHK("address field", 8'h64, rem_rd_data)
    endtask

    task automatic pm_go(input icp_pm_cmd_t c);
        @(negedge core_clk);
        pm_cmd = c;
        pm_cmd_valid = 1'b1;
        do @(posedge core_clk); while (pm_cmd_ready !== 1'b1);
        @(negedge core_clk);
        pm_cmd_valid = 1'b0;
    endtask

    task automatic pm_wait();
        for (int i = 0; i < 20000 && pm_done !== 1'b1; i++)
            @(negedge core_clk);
    endtask

    task automatic t_proxy();
        pm_go({7'h40, 1'b0, 8'h12}); // Far-side target only
        while (m_scl_oe !== 1'b1) @(negedge core_clk);
        comp_sda_low = 1'b1;
        repeat (300) @(negedge core_clk);
        held = 1'b0;
        repeat (400) begin
            @(negedge core_clk);
            held = held | m_scl_oe | m_sda_oe | pm_done;
        end
        `CHK("released after loss", 1'b0, held)
        comp_sda_low = 1'b0; // Stop only once the proxy is off
        while (m_scl_oe !== 1'b1) @(negedge core_clk);
        comp_scl_low = 1'b1;
        repeat (300) @(negedge core_clk);
        `CHK("stretch hold", 2'b00, {m_scl_oe, m_sda_oe})
        comp_scl_low = 1'b0;
        pm_wait();
        `CHK("retry done", 1'b1, pm_done)
        `CHK("no slave ack", 1'b0, pm_ack_ok)
        `CHK("data echo", 8'h12, pm_rd_data)
        pm_go({7'h40, 1'b1, 8'h00});
        pm_wait();
        `CHK("read done", 1'b1, pm_done)
        `CHK("read no ack", 1'b0, pm_ack_ok)
        `CHK("released read", 8'hFF, pm_rd_data)
        `CHK("open drain", 3'b000, {sda_out, m_scl_out, m_sda_out})
    endtask

    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        strap = 3'd0;
        comp_sda_low = 1'b0;
        comp_scl_low = 1'b0;
        rem_req_valid = 1'b0;
        rem_req = '0;
        pm_cmd_valid = 1'b0;
        pm_cmd = '0;
        errors = 0;
        n_compared = 0;
        repeat (12) @(negedge core_clk);
        rstn = 1'b1;
        repeat (2) @(negedge core_clk);
        t_strap();
        t_regs();
        t_remote();
        t_override();
        t_proxy();
        end_of_test();
    end

    initial begin
        #400_000;
        errors++;
        end_of_test();
    end
endmodule // icp_control_port_bench

/* bench/icp_host_model.sv */
/* Host controller model: bus master with start, stop and byte tasks.
   Assumes the bench resolves both wires with pull-ups and feeds SDA back. */
`timescale 1ns/1ps
module icp_host_model #(
    parameter int HALF = 10
) (
    // Clock and resolved data level
    input  wire logic core_clk,
    input  wire logic sda,
    // Pull-down enables of the two wires
    output logic      scl_low,
    output logic      sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic w();
        repeat (HALF) @(negedge core_clk);
    endtask

    // Start or repeated start, data falls while clock high
    task automatic start();
        sda_low = 1'b0;
        w();
        scl_low = 1'b0;
        w();
        sda_low = 1'b1;
        w();
        scl_low = 1'b1;
        w();
    endtask

    // Stop, data rises while clock high
    task automatic stop();
        sda_low = 1'b1;
        w();
        scl_low = 1'b0;
        w();
        sda_low = 1'b0;
        w();
    endtask

    // Wires are only pulled low or released
    task automatic bit_x(input logic b, output logic r);
        @(negedge core_clk);
        sda_low = ~b;
        w();
        scl_low = 1'b0;
        w();
        r = sda;
        scl_low = 1'b1;
    endtask

    // Byte MSB first, then the ninth bit: ack low, nack released
    task automatic xfer(input logic [7:0] tx, input logic last,
                        output logic [7:0] rx, output logic ackn);
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], rx[i]);
        end
        bit_x(last, ackn);
    endtask
endmodule // icp_host_model

/* hw/icp_control_port.sv */
/*
 * Serial control port: bus slave with strap address, shared register file
 * with a back-channel request port, and an arbitrating proxy bus master.
 * Assumes all pins are synchronous to core_clk and pulled up outside.
 */
`timescale 1ns/1ps
module icp_control_port
    import icp_pkg::*;
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // Slave bus pins
    input  wire logic         scl_in,
    input  wire logic         sda_in,
    output logic              sda_out,
    output logic              sda_oe,
    // Strap
    input  wire logic [2:0]   address_select_strap,
    // Back-channel register port
    input  wire logic         rem_req_valid,
    input  wire icp_reg_req_t rem_req,
    output logic              rem_req_ready,
    output logic              rem_rd_valid,
    output logic [7:0]        rem_rd_data,
    // Proxy master command port
    input  wire logic         pm_cmd_valid,
    input  wire icp_pm_cmd_t  pm_cmd,
    output logic              pm_cmd_ready,
    output logic              pm_done,
    output logic              pm_ack_ok,
    output logic [7:0]        pm_rd_data,
    // Proxy master bus pins
    input  wire logic         m_scl_in,
    input  wire logic         m_sda_in,
    output logic              m_scl_out,
    output logic              m_scl_oe,
    output logic              m_sda_out,
    output logic              m_sda_oe
);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // ********************************************
    // Register file and address selection
    // ********************************************
    logic [7:0]        regs_ff [NUM_REGS];
    logic              strap_done_ff;
    logic [6:0]        strap_addr;
    logic [6:0]        own_addr;
    logic              loc_wr;
    logic              rem_acc;
    logic              rem_wr_en;
    logic              rem_ok;
    logic [7:0]        rd_byte;
    logic              rem_rd_valid_ff;
    logic [7:0]        rem_rd_data_ff;
    logic [7:0]        offs_ff;
    logic [7:0]        sh_ff;
    logic [7:0]        byte_in;

    assign strap_addr = STRAP_ADDR_TBL[address_select_strap];
    assign own_addr   = regs_ff[DEV_ID_OFFS[REG_AW-1:0]][OVR_BIT]
                      ? regs_ff[DEV_ID_OFFS[REG_AW-1:0]][7:1]
                      : strap_addr;
    assign rd_byte    = (offs_ff < NUM_REGS)
                      ? regs_ff[offs_ff[REG_AW-1:0]] : 8'h00;
    assign rem_ok        = rem_req.offs < NUM_REGS;
    assign rem_req_ready = ~loc_wr;
    assign rem_acc       = rem_req_valid & rem_req_ready;
    assign rem_wr_en     = rem_acc & rem_req.wr & rem_ok;
    assign rem_rd_valid  = rem_rd_valid_ff;
    assign rem_rd_data   = rem_rd_data_ff;

    // Local write wins the cycle; remote waits one cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_ff[i] <= REG_RST;
            end
            strap_done_ff <= 1'b0;
        end else begin
            strap_done_ff <= 1'b1;
            if (!strap_done_ff) begin
                regs_ff[DEV_ID_OFFS[REG_AW-1:0]] <= {strap_addr, 1'b0};
            end else if (loc_wr) begin
                regs_ff[offs_ff[REG_AW-1:0]] <= byte_in;
            end else if (rem_wr_en) begin
                regs_ff[rem_req.offs[REG_AW-1:0]] <= rem_req.data;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rem_rd_valid_ff <= 1'b0;
            rem_rd_data_ff  <= 8'h00;
        end else begin
            rem_rd_valid_ff <= rem_acc & ~rem_req.wr;
            if (rem_acc && !rem_req.wr) begin
                rem_rd_data_ff <= rem_ok
                                ? regs_ff[rem_req.offs[REG_AW-1:0]] : 8'h00;
            end
        end
    end

    // ********************************************
    // Slave bus engine
    // ********************************************
    icp_sst_t   sst_ff;
    icp_sst_t   nst_ff;
    icp_sst_t   nxt_st;
    logic       scl_q_ff;
    logic       sda_q_ff;
    logic [3:0] cnt_ff;
    logic       ack_ph_ff;
    logic       byte_rdy_ff;
    logic       ack_want_ff;
    logic       mack_ff;
    logic       sda_oe_ff;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       active;
    logic       rx_last;
    logic       addr_match;
    logic       nxt_ack;

    assign scl_rise   = scl_in & ~scl_q_ff;
    assign scl_fall   = ~scl_in & scl_q_ff;
    assign start_det  = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
    assign stop_det   = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
    assign active     = (sst_ff != SS_IDLE) && (sst_ff != SS_IGNORE);
    assign byte_in    = {sh_ff[6:0], sda_in};
    assign rx_last    = active & scl_rise & ~ack_ph_ff & (cnt_ff == 4'h7);
    assign addr_match = byte_in[7:1] == own_addr;
    assign loc_wr     = rx_last & (sst_ff == SS_WDATA)
                      & (offs_ff < NUM_REGS) & strap_done_ff;
    assign nxt_ack    = (sst_ff == SS_ADDR) ? addr_match
                      : (sst_ff == SS_OFFS) || (sst_ff == SS_WDATA);
    assign sda_out    = 1'b0;
    assign sda_oe     = sda_oe_ff;

    always_comb begin
        case (sst_ff)
            SS_ADDR:  nxt_st = !addr_match ? SS_IGNORE
                             : (byte_in[0] ? SS_RDATA : SS_OFFS);
            SS_OFFS:  nxt_st = SS_WDATA;
            SS_WDATA: nxt_st = SS_WDATA;
            SS_RDATA: nxt_st = SS_RDATA;
            default:  nxt_st = SS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
            sst_ff <= SS_IDLE;
            nst_ff <= SS_IDLE;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            offs_ff <= 8'h00;
            ack_ph_ff <= 1'b0;
            byte_rdy_ff <= 1'b0;
            ack_want_ff <= 1'b0;
            mack_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else begin
            scl_q_ff <= scl_in;
            sda_q_ff <= sda_in;
            if (stop_det) begin
                sst_ff <= SS_IDLE;
                sda_oe_ff <= 1'b0;
                ack_ph_ff <= 1'b0;
                byte_rdy_ff <= 1'b0;
            end else if (start_det) begin
                sst_ff <= SS_ADDR;
                cnt_ff <= 4'h0;
                sda_oe_ff <= 1'b0;
                ack_ph_ff <= 1'b0;
                byte_rdy_ff <= 1'b0;
            end else if (active) begin
                if (scl_rise && !ack_ph_ff) begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (sst_ff != SS_RDATA) begin
                        sh_ff <= byte_in;
                    end
                    if (cnt_ff == 4'h7) begin
                        byte_rdy_ff <= 1'b1;
                        ack_want_ff <= nxt_ack;
                        nst_ff <= nxt_st;
                        if (sst_ff == SS_OFFS) begin
                            offs_ff <= byte_in;
                        end else if (sst_ff == SS_WDATA) begin
                            offs_ff <= offs_ff + 8'h01;
                        end
                    end
                end
                if (scl_rise && ack_ph_ff) begin
                    mack_ff <= ~sda_in;
                end
                if (scl_fall) begin
                    if (byte_rdy_ff) begin
                        byte_rdy_ff <= 1'b0;
                        ack_ph_ff <= 1'b1;
                        sda_oe_ff <= (sst_ff != SS_RDATA) & ack_want_ff;
                    end else if (ack_ph_ff) begin
                        ack_ph_ff <= 1'b0;
                        cnt_ff <= 4'h0;
                        if (sst_ff == SS_RDATA && !mack_ff) begin
                            sst_ff <= SS_IGNORE;
                            sda_oe_ff <= 1'b0;
                        end else if (nst_ff == SS_RDATA) begin
                            sst_ff <= SS_RDATA;
                            sh_ff <= rd_byte;
                            sda_oe_ff <= ~rd_byte[7];
                            offs_ff <= offs_ff + 8'h01;
                        end else begin
                            sst_ff <= nst_ff;
                            sda_oe_ff <= 1'b0;
                        end
                    end else if (sst_ff == SS_RDATA) begin
                        sh_ff <= {sh_ff[6:0], 1'b0};
                        sda_oe_ff <= ~sh_ff[6];
                    end
                end
            end
        end
    end

    // ********************************************
    // Proxy master
    // ********************************************
    icp_mst_t    mst_ff;
    icp_pm_cmd_t cmd_ff;
    logic [1:0]  ph_ff;
    logic [7:0]  div_ff;
    logic [4:0]  bit_ff;
    logic [17:0] rx_ff;
    logic        m_scl_oe_ff;
    logic        m_sda_oe_ff;
    logic        mscl_q_ff;
    logic        msda_q_ff;
    logic        done_ff;
    logic        tick;
    logic [17:0] frame;
    logic [17:0] own_mask;
    logic        cur_bit;
    logic        own_bit;
    logic        m_stop_det;
    logic        arb_lost;

    assign tick       = div_ff == 8'(QTR_BIT_CYC - 1);
    assign frame      = {cmd_ff.addr, cmd_ff.rnw, 1'b1,
                         cmd_ff.rnw ? 8'hFF : cmd_ff.data, 1'b1};
    assign own_mask   = cmd_ff.rnw ? OWN_MASK_RD : OWN_MASK_WR;
    assign cur_bit    = frame[bit_ff];
    assign own_bit    = own_mask[bit_ff];
    assign m_stop_det = m_scl_in & mscl_q_ff & ~msda_q_ff & m_sda_in;
    assign arb_lost   = (mst_ff == MS_BIT) && (ph_ff == 2'd2) && tick
                      && m_scl_in && own_bit && cur_bit && !m_sda_in;
    assign pm_cmd_ready = mst_ff == MS_IDLE;
    assign pm_done    = done_ff;
    assign pm_ack_ok  = ~rx_ff[9] & (cmd_ff.rnw | ~rx_ff[0]);
    assign pm_rd_data = rx_ff[8:1];
    assign m_scl_out  = 1'b0;
    assign m_sda_out  = 1'b0;
    assign m_scl_oe   = m_scl_oe_ff;
    assign m_sda_oe   = m_sda_oe_ff;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            div_ff <= 8'h00;
            mscl_q_ff <= 1'b1;
            msda_q_ff <= 1'b1;
        end else begin
            div_ff <= tick ? 8'h00 : div_ff + 8'h01;
            mscl_q_ff <= m_scl_in;
            msda_q_ff <= m_sda_in;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mst_ff <= MS_IDLE;
            cmd_ff <= '0;
            ph_ff <= 2'd0;
            bit_ff <= 5'd0;
            rx_ff <= 18'h00000;
            m_scl_oe_ff <= 1'b0;
            m_sda_oe_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (mst_ff)
                MS_IDLE: if (pm_cmd_valid) begin
                    cmd_ff <= pm_cmd;
                    mst_ff <= MS_START;
                    ph_ff <= 2'd0;
                end
                MS_START: if (tick) begin
                    if (ph_ff == 2'd0 && m_scl_in && m_sda_in) begin
                        m_sda_oe_ff <= 1'b1;
                        ph_ff <= 2'd1;
                    end else if (ph_ff == 2'd1) begin
                        m_scl_oe_ff <= 1'b1;
                        mst_ff <= MS_BIT;
                        bit_ff <= 5'(FRAME_BITS - 1);
                        ph_ff <= 2'd0;
                    end
                end
                MS_BIT: if (arb_lost) begin
                    m_sda_oe_ff <= 1'b0;
                    m_scl_oe_ff <= 1'b0;
                    mst_ff <= MS_LOST;
                end else if (tick) begin
                    case (ph_ff)
                        2'd0: begin
                            m_sda_oe_ff <= ~cur_bit;
                            ph_ff <= 2'd1;
                        end
                        2'd1: begin
                            m_scl_oe_ff <= 1'b0;
                            ph_ff <= 2'd2;
                        end
                        2'd2: if (m_scl_in) begin
                            rx_ff[bit_ff] <= m_sda_in;
                            ph_ff <= 2'd3;
                        end
                        default: begin
                            m_scl_oe_ff <= 1'b1;
                            ph_ff <= 2'd0;
                            if (bit_ff == 5'd0) begin
                                mst_ff <= MS_STOP;
                            end else begin
                                bit_ff <= bit_ff - 5'd1;
                            end
                        end
                    endcase
                end
                MS_STOP: if (tick) begin
                    if (ph_ff == 2'd0) begin
                        m_sda_oe_ff <= 1'b1;
                        ph_ff <= 2'd1;
                    end else if (ph_ff == 2'd1) begin
                        m_scl_oe_ff <= 1'b0;
                        ph_ff <= 2'd2;
                    end else if (m_scl_in) begin
                        m_sda_oe_ff <= 1'b0;
                        done_ff <= 1'b1;
                        mst_ff <= MS_IDLE;
                    end
                end
                MS_LOST: if (m_stop_det) begin
                    mst_ff <= MS_START;
                    ph_ff <= 2'd0;
                end
                default: mst_ff <= MS_IDLE;
            endcase
        end
    end

    // ********************************************
    // Checks
    // ********************************************
    addr_select_a: assert property ((sst_ff == SS_ADDR && rx_last) |=>
        (nst_ff == SS_IGNORE) == ($past(byte_in[7:1]) != $past(own_addr)))
        else $error("address decision wrong");
    strap_map_a: assert property ((strap_done_ff && !regs_ff[0][0]) |->
        own_addr == STRAP_ADDR_TBL[address_select_strap])
        else $error("strap address wrong");
    start_open_a: assert property ((sst_ff == SS_ADDR
        && $past(sst_ff) != SS_ADDR) |-> $past(start_det))
        else $error("frame opened without start");
    stop_idle_a: assert property (stop_det |=>
        sst_ff == SS_IDLE && !sda_oe_ff)
        else $error("stop not honoured");
    addr_ack_a: assert property ((sst_ff == SS_ADDR && byte_rdy_ff
        && scl_fall) |=> ack_ph_ff && sda_oe_ff == $past(ack_want_ff))
        else $error("address ack wrong");
    write_ack_a: assert property ((sst_ff == SS_WDATA && byte_rdy_ff
        && scl_fall) |=> ack_ph_ff && sda_oe_ff)
        else $error("write byte not acked");
    line_drive_a: assert property (!sda_out && !m_sda_out && !m_scl_out)
        else $error("line driven high");
    clk_stretch_a: assert property ((mst_ff == MS_BIT && ph_ff == 2'd2
        && !m_scl_in) |=> mst_ff == MS_BIT && ph_ff == 2'd2)
        else $error("stretch not tolerated");
    arb_loss_a: assert property (arb_lost |=>
        mst_ff == MS_LOST && !m_sda_oe_ff && !m_scl_oe_ff)
        else $error("arbitration loss missed");
    retry_idle_a: assert property ((mst_ff == MS_LOST && m_stop_det)
        |=> mst_ff == MS_START && ph_ff == 2'd0)
        else $error("no retry after idle");
    reg_arb_a: assert property ((loc_wr && rem_req_valid) |->
        !rem_req_ready ##1 rem_req_ready)
        else $error("register access collision");
    same_reg_a: assert property (rem_wr_en |=>
        regs_ff[$past(rem_req.offs[REG_AW-1:0])] == $past(rem_req.data))
        else $error("remote write lost");

endmodule // icp_control_port

/* hw/icp_pkg.sv */
/*
 * Constants, state encodings and carrier types of the serial control port.
 * Assumes a single 200 MHz core clock shared by every user of the package.
 */
package icp_pkg;

    // ********************************************
    // Timing
    // ********************************************
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned QTR_BIT_NS    = 250;
    localparam int unsigned QTR_BIT_CYC   =
        (QTR_BIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ********************************************
    // Addressing and register file
    // ********************************************
    localparam logic [7:0][6:0] STRAP_ADDR_TBL = {
        7'h3C, 7'h38, 7'h36, 7'h34, 7'h32, 7'h30, 7'h2E, 7'h2C};
    localparam int unsigned NUM_REGS    = 32;
    localparam int unsigned REG_AW      = 5;
    localparam logic [7:0]  DEV_ID_OFFS = 8'h00;
    localparam int unsigned OVR_BIT     = 0;
    localparam logic [7:0]  REG_RST     = 8'h00;

    // ********************************************
    // Proxy master frame: address, ack, data, ack
    // ********************************************
    localparam int unsigned FRAME_BITS  = 18;
    localparam logic [17:0] OWN_MASK_WR = 18'h3FDFE;
    localparam logic [17:0] OWN_MASK_RD = 18'h3FC00;

    // ********************************************
    // States and carriers
    // ********************************************
    typedef enum logic [2:0] {
        SS_IDLE   = 3'b000,
        SS_ADDR   = 3'b001,
        SS_OFFS   = 3'b010,
        SS_WDATA  = 3'b011,
        SS_RDATA  = 3'b100,
        SS_IGNORE = 3'b101
    } icp_sst_t;

    typedef enum logic [2:0] {
        MS_IDLE  = 3'b000,
        MS_START = 3'b001,
        MS_BIT   = 3'b010,
        MS_STOP  = 3'b011,
        MS_LOST  = 3'b100
    } icp_mst_t;

    typedef struct packed {
        logic       wr;
        logic [7:0] offs;
        logic [7:0] data;
    } icp_reg_req_t;

    typedef struct packed {
        logic [6:0] addr;
        logic       rnw;
        logic [7:0] data;
    } icp_pm_cmd_t;

endpackage
